/* File: design/dsb_status_defines.svh */
/*
  Offsets, field positions, reset values and timing counts for the
  sideband bus status block.
  Assumes a 25 MHz controller clock and a 32-bit classic Wishbone bus.
*/
`ifndef DSB_STATUS_DEFINES_SVH
`define DSB_STATUS_DEFINES_SVH

// ==========================================================
// register byte offsets
`define DSB_OFS_STATUS_A   12'he80
`define DSB_OFS_STATUS_B   12'he90
`define DSB_OFS_CTRL       12'hea0
`define DSB_OFS_IRQ_STAT   12'hea4
`define DSB_OFS_IRQ_MASK   12'hea8
`define DSB_ADDR_W         12

// ==========================================================
// status word fields
`define DSB_ST_RDVALID     31
`define DSB_ST_WRDONE      30
`define DSB_ST_BUSERR      29
`define DSB_ST_LINKBUSY    28
`define DSB_ST_IDX_LO      24
`define DSB_ST_DATA_W      16
`define DSB_IDX_W          3
`define DSB_IDX_RST        3'h0

// ==========================================================
// control and interrupt fields
`define DSB_CTRL_POLLEN    0
`define DSB_CTRL_RST       32'h0000_0000
`define DSB_IRQ_W          6
`define DSB_IRQ_PER_INST   3
`define DSB_IRQ_RD         0
`define DSB_IRQ_WR         1
`define DSB_IRQ_ERR        2
`define DSB_IRQ_RST        6'h00

// ==========================================================
// command source codes from the transaction engine
`define DSB_SRC_MANUAL     2'h0
`define DSB_SRC_POLL       2'h1
`define DSB_SRC_MSG        2'h2

// ==========================================================
// timing
`define DSB_CLK_KHZ        25000
`define DSB_POLL_PERIOD_US 1000
`define DSB_POLL_CYC       (`DSB_POLL_PERIOD_US * `DSB_CLK_KHZ / 1000)
`define DSB_POLL_CNT_W     24
`define DSB_ACK_BIT        8
`define DSB_RW_BIT         7

`endif

/* File: design/dsb_pkg.sv */
/*
  Types shared by the sideband bus status block.
  Assumes the defines header is compiled alongside.
*/
package dsb_pkg;
  // poll sequencer states
  typedef enum logic [1:0] {
    POLL_WAIT,
    POLL_REQ,
    POLL_BUSY
  } dsb_poll_e;

  // register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STAT_A,
    SEL_STAT_B,
    SEL_CTRL,
    SEL_IRQ_STAT,
    SEL_IRQ_MASK
  } dsb_sel_e;

  typedef logic [2:0] dsb_idx_t;
endpackage

/* File: design/dsb_mon_if.sv */
/*
  Carrier between a link monitor and the status block.
  Assumes both ends run on the controller clock.
*/
`timescale 1ns/1ps
interface dsb_mon_if;
  logic nack;   // one-cycle pulse: not-acknowledge at an ack slot
  logic busy;   // level: frame in progress between start and stop

  modport mon  (output nack, output busy);
  modport user (input nack, input busy);
endinterface

/* File: design/dsb_link_mon.sv */
/*
  Watches one two-wire sideband link and reports a not-acknowledge
  seen at an expected ack slot.
  Assumes the link pins are asynchronous to clk and much slower.
*/
`timescale 1ns/1ps
`include "dsb_status_defines.svh"

module dsb_link_mon
  import dsb_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  input wire logic   sclPin,
  input wire logic   sdaPin,
  dsb_mon_if.mon     mon
);

  logic       sclS1, sclS2, sclD;
  logic       sdaS1, sdaS2, sdaD;
  logic [3:0] bitCnt;
  logic       firstByte;
  logic       isRead;
  logic       startSeen, stopSeen, sclRise, ackSlot;

  // ========================================================
  // synchronisers; logic reads the second stage and its delayed copy, never the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sclD  <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaD  <= 1'b1;
    end else begin
      sclS1 <= sclPin;
      sclS2 <= sclS1;
      sclD  <= sclS2;
      sdaS1 <= sdaPin;
      sdaS2 <= sdaS1;
      sdaD  <= sdaS2;
    end
  end

  // line conditions
  assign startSeen = sclS2 && sclD && sdaD && !sdaS2;
  assign stopSeen  = sclS2 && sclD && !sdaD && sdaS2;
  assign sclRise   = sclS2 && !sclD;
  assign ackSlot   = sclRise && mon.busy && (bitCnt == 4'(`DSB_ACK_BIT));

  // ========================================================
  // bit counter; a stretched clock only delays the next rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon.busy  <= 1'b0;
      bitCnt    <= 4'h0;
      firstByte <= 1'b0;
      isRead    <= 1'b0;
    end else if (startSeen) begin
      mon.busy  <= 1'b1;
      bitCnt    <= 4'h0;
      firstByte <= 1'b1;
    end else if (stopSeen) begin
      mon.busy  <= 1'b0;
    end else if (sclRise && mon.busy) begin
      if (ackSlot) begin
        bitCnt    <= 4'h0;
        firstByte <= 1'b0;
      end else begin
        bitCnt <= bitCnt + 4'h1;
      end
      if (firstByte && bitCnt == 4'(`DSB_RW_BIT)) begin
        isRead <= sdaS2;
      end
    end
  end

  // ========================================================
  // read data bytes end with the master's own nack, so only the
  // address ack of a read is checked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon.nack <= 1'b0;
    end else begin
      mon.nack <= ackSlot && sdaS2 && (firstByte || !isRead); // R7
    end
  end

endmodule // dsb_link_mon

/* File: design/dsb_status_top.sv */
/*
  Status flags of the two sideband bus instances of the memory
  controller, the periodic thermal sensor poll sequencer, interrupt
  logic and a classic Wishbone slave.
  Assumes a transaction engine on clk that reports command issue and
  completion, and the two link pin pairs arriving asynchronously.
*/
// Chosen here: register access over Wishbone.
// Notes on behaviour
// R1 - manual read done sets read-valid
// R2 - next manual read issue clears read-valid
// R3 - write completion sets write-done
// R4 - next write issue clears write-done
// R5 - nack at ack slot sets bus-error
// R6 - error check covers every source
// R7 - stretching alone never flags an error
// R8 - no hardware polling while bus-error set
// R9 - sensor index held while bus-error set
// R10 - manual issue allowed, clears bus-error
// R11 - polling resumes from held index
`timescale 1ns/1ps
`include "dsb_status_defines.svh"

module dsb_status_top
  import dsb_pkg::*;
#(
  parameter int unsigned POLL_CYC = `DSB_POLL_CYC
)(
  input  wire logic                       clk,
  input  wire logic                       rst,
  // classic wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [`DSB_ADDR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output      logic [31:0]                wb_dat_o,
  output      logic                       wb_ack_o,

  // transaction engine, one lane per instance
  input  wire logic [1:0]                 cmdIssue,
  input  wire logic [1:0]                 cmdRead,
  input  wire logic [3:0]                 cmdSrc,
  input  wire logic [1:0]                 cmdDone,
  input  wire logic [2*`DSB_ST_DATA_W-1:0] rdData,
  input  wire logic [1:0]                 pollGrant,
  output      logic [1:0]                 pollReq,
  output      logic [2*`DSB_IDX_W-1:0]    pollIndex,

  // link pins, sampled only
  input  wire logic [1:0]                 sclIn,
  input  wire logic [1:0]                 sdaIn,

  // interrupt
  output      logic                       irq
);

  // ========================================================
  // per instance state
  logic [1:0]                    rdValidReg;
  logic [1:0]                    wrDoneReg;
  logic [1:0]                    busErrReg;
  logic [1:0]                    linkBusy;
  logic [1:0]                    nackSeen;
  logic [2*`DSB_ST_DATA_W-1:0]   dataReg;
  logic [2*`DSB_IDX_W-1:0]       idxReg;
  logic [1:0]                    evRd;
  logic [1:0]                    evWr;
  logic [1:0]                    evErr;

  // register file
  logic [31:0]                   ctrlReg;
  // interrupt status, mask and events
  logic [`DSB_IRQ_W-1:0]         irqStatReg;
  logic [`DSB_IRQ_W-1:0]         irqMaskReg;
  logic [`DSB_IRQ_W-1:0]         irqEvents;
  logic [`DSB_IRQ_W-1:0]         irqClr;

  // bus side
  logic                          busReq;
  logic                          busWrite;
  dsb_sel_e                      selNow;
  logic [31:0]                   rdMux;

  // index leaves straight from its flip-flops
  assign pollIndex = idxReg;

  // ========================================================
  // address decode, shared by the read mux and the write path
  // offsets outside the map fall to SEL_NONE
  function automatic dsb_sel_e decodeAddr(
    input logic [`DSB_ADDR_W-1:0] adr
  );
    dsb_sel_e sel;
    sel = SEL_NONE;
    unique case (adr)
      `DSB_OFS_STATUS_A: sel = SEL_STAT_A;
      `DSB_OFS_STATUS_B: sel = SEL_STAT_B;
      `DSB_OFS_CTRL:     sel = SEL_CTRL;
      `DSB_OFS_IRQ_STAT: sel = SEL_IRQ_STAT;
      `DSB_OFS_IRQ_MASK: sel = SEL_IRQ_MASK;
      default:           sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // status word of one instance
  // bits not listed read as zero
  function automatic logic [31:0] statusWord(input int unsigned i);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`DSB_ST_RDVALID]  = rdValidReg[i];
    w[`DSB_ST_WRDONE]   = wrDoneReg[i];
    w[`DSB_ST_BUSERR]   = busErrReg[i];
    w[`DSB_ST_LINKBUSY] = linkBusy[i];
    w[`DSB_ST_IDX_LO +: `DSB_IDX_W] = idxReg[i*`DSB_IDX_W +: `DSB_IDX_W];
    w[`DSB_ST_DATA_W-1:0] = dataReg[i*`DSB_ST_DATA_W +: `DSB_ST_DATA_W];
    return w;
  endfunction

  // ========================================================
  // one lane per instance: monitor, flags, poll sequencer
  // lane g owns its own bits of every per-lane vector
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_inst
      dsb_mon_if monIf ();
      dsb_poll_e                pollState;
      logic [`DSB_POLL_CNT_W-1:0] pollCnt;
      logic                     manualIssue;
      logic                     pollDone;
      logic                     errNow;

      // pins are synchronised inside the monitor
      dsb_link_mon u_mon (
        .clk    (clk),
        .rst    (rst),
        .sclPin (sclIn[g]),
        .sdaPin (sdaIn[g]),
        .mon    (monIf)
      );

      // monitor outputs and command qualifiers
      assign nackSeen[g] = monIf.nack; // R6
      assign linkBusy[g] = monIf.busy;
      assign manualIssue = cmdIssue[g] &&
                           cmdSrc[2*g +: 2] == `DSB_SRC_MANUAL;
      assign pollDone    = cmdDone[g] &&
                           cmdSrc[2*g +: 2] == `DSB_SRC_POLL;
      // an error raised this very cycle counts already
      assign errNow      = busErrReg[g] || nackSeen[g];

      // read-valid: a set in the clearing cycle wins, so a read
      // ending as the next one starts is not lost
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          rdValidReg[g] <= 1'b0;
        end else if (evRd[g]) begin
          rdValidReg[g] <= 1'b1; // R1
        end else if (manualIssue && cmdRead[g]) begin
          rdValidReg[g] <= 1'b0; // R2
        end
      end

      // read data field, loaded together with read-valid
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          dataReg[g*`DSB_ST_DATA_W +: `DSB_ST_DATA_W] <= '0;
        end else if (evRd[g]) begin
          dataReg[g*`DSB_ST_DATA_W +: `DSB_ST_DATA_W] <=
            rdData[g*`DSB_ST_DATA_W +: `DSB_ST_DATA_W]; // R1
        end
      end

      // write-done: set by a write of any source, cleared by the
      // issue of any later write
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          wrDoneReg[g] <= 1'b0;
        end else if (evWr[g]) begin
          wrDoneReg[g] <= 1'b1; // R3
        end else if (cmdIssue[g] && !cmdRead[g]) begin
          wrDoneReg[g] <= 1'b0; // R4
        end
      end

      // bus-error: a nack wins over a manual clear in the same cycle
      // only a manual issue clears it
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          busErrReg[g] <= 1'b0;
        end else if (nackSeen[g]) begin
          busErrReg[g] <= 1'b1; // R5
        end else if (manualIssue) begin
          busErrReg[g] <= 1'b0; // R10
        end
      end

      // events; a failed manual read does not flag valid data
      // error event only on the rise of the flag
      assign evRd[g]  = cmdDone[g] && cmdRead[g] &&
                        cmdSrc[2*g +: 2] == `DSB_SRC_MANUAL && !errNow;
      assign evWr[g]  = cmdDone[g] && !cmdRead[g] && !errNow;
      assign evErr[g] = nackSeen[g] && !busErrReg[g];

      // poll sequencer: interval timer, request, wait for completion
      // the timer restarts from zero after an error
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pollState  <= POLL_WAIT;
          pollCnt    <= '0;
          pollReq[g] <= 1'b0;
        end else begin
          unique case (pollState)
            POLL_WAIT: begin
              // held while off or in error
              if (!ctrlReg[`DSB_CTRL_POLLEN] || errNow) begin
                pollCnt <= '0; // R8
              end else if (pollCnt >= `DSB_POLL_CNT_W'(POLL_CYC - 1)) begin
                pollCnt    <= '0;
                pollState  <= POLL_REQ; // R11
                pollReq[g] <= 1'b1;
              end else begin
                pollCnt <= pollCnt + 1'b1;
              end
            end
            POLL_REQ: begin
              // a fresh error withdraws the request
              if (errNow) begin
                pollState  <= POLL_WAIT; // R8
                pollReq[g] <= 1'b0;
              end else if (pollGrant[g]) begin
                pollState  <= POLL_BUSY;
                pollReq[g] <= 1'b0;
              end
            end
            POLL_BUSY: begin
              // a poll in flight always runs to done
              if (pollDone) begin
                pollState <= POLL_WAIT;
              end
            end
          endcase
        end
      end

      // sensor index advances only after a clean poll
      // wraps from the last sensor back to zero
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          idxReg[g*`DSB_IDX_W +: `DSB_IDX_W] <= `DSB_IDX_RST;
        end else if (pollState == POLL_BUSY && pollDone && !errNow) begin
          idxReg[g*`DSB_IDX_W +: `DSB_IDX_W] <=
            idxReg[g*`DSB_IDX_W +: `DSB_IDX_W] + 1'b1; // R9
        end
      end

      // interrupt event bits of this lane
      // three per lane: read, write, error
      assign irqEvents[g*`DSB_IRQ_PER_INST + `DSB_IRQ_RD]  = evRd[g];
      assign irqEvents[g*`DSB_IRQ_PER_INST + `DSB_IRQ_WR]  = evWr[g];
      assign irqEvents[g*`DSB_IRQ_PER_INST + `DSB_IRQ_ERR] = evErr[g];
    end
  endgenerate

  // ========================================================
  // wishbone slave: ack one cycle after the request, one cycle wide
  // the ack gate keeps a held request from being taken twice
  assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWrite = busReq && wb_we_i;
  assign selNow   = decodeAddr(wb_adr_i);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // read mux; unmapped addresses read zero and still ack
  // decoded from the live address, captured on the request edge
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (selNow)
      SEL_STAT_A:   rdMux = statusWord(0);
      SEL_STAT_B:   rdMux = statusWord(1);
      SEL_CTRL:     rdMux = ctrlReg;
      SEL_IRQ_STAT: rdMux = {{(32-`DSB_IRQ_W){1'b0}}, irqStatReg};
      SEL_IRQ_MASK: rdMux = {{(32-`DSB_IRQ_W){1'b0}}, irqMaskReg};
      SEL_NONE:     rdMux = 32'h0000_0000;
    endcase
  end

  // read data register; holds until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq && !wb_we_i) begin
      wb_dat_o <= rdMux;
    end
  end

  // control register; only the poll enable bit is kept
  // other bits stay at their reset value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlReg <= `DSB_CTRL_RST;
    end else if (busWrite && selNow == SEL_CTRL && wb_sel_i[0]) begin
      ctrlReg[`DSB_CTRL_POLLEN] <= wb_dat_i[`DSB_CTRL_POLLEN];
    end
  end

  // ========================================================
  // interrupts: sticky status, write one to clear, set wins
  // a clear in the event cycle loses, so no event is missed
  assign irqClr = (busWrite && selNow == SEL_IRQ_STAT && wb_sel_i[0]) ?
                  wb_dat_i[`DSB_IRQ_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatReg <= `DSB_IRQ_RST;
    end else begin
      irqStatReg <= (irqStatReg & ~irqClr) | irqEvents;
    end
  end

  // interrupt mask, same layout as the status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqMaskReg <= `DSB_IRQ_RST;
    end else if (busWrite && selNow == SEL_IRQ_MASK && wb_sel_i[0]) begin
      irqMaskReg <= wb_dat_i[`DSB_IRQ_W-1:0];
    end
  end

  // registered so the output comes straight from a flip-flop
  // costs one cycle of interrupt latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatReg & irqMaskReg);
    end
  end

endmodule // dsb_status_top

/* File: sim/dsb_status_chk.sv */
/*
  Checker for the sideband bus status block.
  Assumes binding to dsb_status_top; sees its ports only.
*/
`timescale 1ns/1ps
`include "dsb_status_defines.svh"

module dsb_status_chk (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [`DSB_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic [1:0]             cmdIssue,
  input wire logic [1:0]             cmdRead,
  input wire logic [3:0]             cmdSrc,
  input wire logic [1:0]             cmdDone,
  input wire logic [1:0]             pollGrant,
  input wire logic [1:0]             pollReq,
  input wire logic [5:0]             pollIndex
);
  logic rdPend_reg;  // manual read open on lane 0
  logic wrPend_reg;  // write open on lane 1

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // open commands; done wins, since done may set the flag again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdPend_reg <= 1'b0;
    else if (cmdDone[0]) rdPend_reg <= 1'b0;
    else if (cmdIssue[0] && cmdRead[0] && cmdSrc[1:0] == `DSB_SRC_MANUAL)
      rdPend_reg <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) wrPend_reg <= 1'b0;
    else if (cmdDone[1]) wrPend_reg <= 1'b0;
    else if (cmdIssue[1] && !cmdRead[1]) wrPend_reg <= 1'b1;
  end

  // ==========================================================
  // register bus and flags
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UNMAPPED: assert property (wb_ack_o && !$past(wb_we_i) &&
    !($past(wb_adr_i) inside {`DSB_OFS_STATUS_A, `DSB_OFS_STATUS_B,
    `DSB_OFS_CTRL, `DSB_OFS_IRQ_STAT, `DSB_OFS_IRQ_MASK})
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_CLEAR: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(rdPend_reg) &&
    $past(wb_adr_i) == `DSB_OFS_STATUS_A
    |-> !wb_dat_o[`DSB_ST_RDVALID])
    else $error("read valid seen while a read is open");
  AST_WR_CLEAR: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wrPend_reg) &&
    $past(wb_adr_i) == `DSB_OFS_STATUS_B
    |-> !wb_dat_o[`DSB_ST_WRDONE])
    else $error("write done seen while a write is open");

  // ==========================================================
  // poll sequencer: index moves only on a poll done, on lane 0 by one
  AST_IDX_HOLD_A: assert property ($changed(pollIndex[2:0]) |->
    $past(cmdDone[0]) && $past(cmdSrc[1:0]) == `DSB_SRC_POLL)
    else $error("lane 0 index moved without a poll done");
  AST_IDX_HOLD_B: assert property ($changed(pollIndex[5:3]) |->
    $past(cmdDone[1]) && $past(cmdSrc[3:2]) == `DSB_SRC_POLL)
    else $error("lane 1 index moved without a poll done");
  AST_IDX_STEP: assert property ($changed(pollIndex[2:0]) |->
    pollIndex[2:0] == $past(pollIndex[2:0]) + 3'h1)
    else $error("lane 0 index did not step by one");
  AST_REQ_GRANT: assert property (
    pollReq[0] && pollGrant[0] |=> !pollReq[0])
    else $error("poll request stands after grant");
endmodule  // dsb_status_chk

bind dsb_status_top dsb_status_chk u_chk (
  .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .cmdIssue, .cmdRead, .cmdSrc, .cmdDone, .pollGrant,
  .pollReq, .pollIndex
);

/* File: sim/dsb_link_model.sv */
/*
  Behavioural two-wire link: plays one address byte to a target that
  acknowledges or not, optionally stretching the clock low.
  Assumes idle lines rest high through pull-ups.
*/
`timescale 1ns/1ps

module dsb_link_model #(
  parameter logic [6:0] TGT_ADDR = 7'h2a  // arbitrary target address
)(
  output logic scl,
  output logic sda
);
  localparam time HALF = 160ns;  // 320 ns link period

  // idle: clock stands still high, data released high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // offset keeps every line change away from the clk edges
  task automatic frame(input logic nackBit, input int stretch);
    logic [8:0] w;
    w = {TGT_ADDR, 1'b0, nackBit};  // released ack slot means nack
    #7;
    #(HALF/2) sda = 1'b0;
    #(HALF/2) scl = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      #(HALF/2) sda = w[i];
      #(HALF/2 + stretch) scl = 1'b1;
      #HALF scl = 1'b0;
    end
    #(HALF/2) sda = 1'b0;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) sda = 1'b1;
  endtask
endmodule  // dsb_link_model

/* File: sim/tb_dimm_sideband_bus_status.sv */
/*
  Self-checking bench: register access, flag set and clear,
  interrupt, link errors and error-gated polling.
  Assumes the design, checker and link model are compiled first.
*/
`timescale 1ns/1ps
`include "dsb_status_defines.svh"

module tb_dimm_sideband_bus_status;
  logic        clk, rst, cyc, stb, we, ack, irq;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q, rdData;
  logic [1:0]  issue, isRd, done, grant, pollReq;
  logic [3:0]  src, sel;
  logic [5:0]  pollIndex;
  wire         scl0, scl1, sda0, sda1;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;

  dsb_status_top #(.POLL_CYC(20)) u_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmdIssue(issue),
    .cmdRead(isRd), .cmdSrc(src), .cmdDone(done), .rdData(rdData),
    .pollGrant(grant), .pollReq(pollReq), .pollIndex(pollIndex),
    .sclIn({scl1, scl0}), .sdaIn({sda1, sda0}), .irq(irq)
  );
  dsb_link_model u_link0 (.scl(scl0), .sda(sda0));
  dsb_link_model u_link1 (.scl(scl1), .sda(sda1));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // classic cycle: hold until ack is sampled, then release
  task automatic wb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("bus ack latency", 32'h2, n);
  endtask

  task automatic cmd(int l, logic r, logic [1:0] s);
    @(posedge clk);
    issue[l] <= 1'b1;
    isRd[l] <= r;
    src[2*l +: 2] <= s;
    @(posedge clk);
    issue[l] <= 1'b0;
  endtask

  task automatic fin(int l, logic [15:0] d);
    @(posedge clk);
    done[l] <= 1'b1;
    rdData[16*l +: 16] <= d;
    @(posedge clk);
    done[l] <= 1'b0;
  endtask

  // one lane 0 poll round; the nack makes it fail on the wire
  task automatic poll(logic nack);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pollReq[0] !== 1'b1 && n < 100);
    if (n >= 100) chk("poll request", 32'h1, 32'h0);
    grant[0] <= 1'b1;
    @(posedge clk);
    grant[0] <= 1'b0;
    cmd(0, 1'b1, `DSB_SRC_POLL);
    if (nack) u_link0.frame(1'b1, 0);
    repeat (6) @(posedge clk);
    fin(0, 16'h0);
    @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wb(1'b1, `DSB_OFS_STATUS_B, 32'hffff_ffff);  // read only
    wb(1'b0, `DSB_OFS_STATUS_B, 32'h0);
    chk("status b", 32'h0, q);
    wb(1'b1, 12'hff0, 32'hffff_ffff);
    wb(1'b0, 12'hff0, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b0, `DSB_OFS_CTRL, 32'h0);
    chk("ctrl", `DSB_CTRL_RST, q);
  endtask

  task automatic t_read();
    cmd(0, 1'b1, `DSB_SRC_MANUAL);
    fin(0, 16'h5a3c);
    wb(1'b0, `DSB_OFS_STATUS_A, 32'h0);
    chk("read word", 32'h8000_5a3c, q & 32'he000_ffff);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, `DSB_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wb(1'b1, `DSB_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    cmd(0, 1'b1, `DSB_SRC_MANUAL);
    wb(1'b0, `DSB_OFS_STATUS_A, 32'h0);
    chk("read valid", 32'h0, q & 32'h8000_0000);
    fin(0, 16'h0011);
  endtask

  task automatic t_write();
    cmd(1, 1'b0, `DSB_SRC_MSG);
    fin(1, 16'h0);
    wb(1'b0, `DSB_OFS_STATUS_B, 32'h0);
    chk("write done", 32'h4000_0000, q & 32'h4000_0000);
    cmd(1, 1'b0, `DSB_SRC_MANUAL);
    wb(1'b0, `DSB_OFS_STATUS_B, 32'h0);
    chk("write cleared", 32'h0, q & 32'h4000_0000);
    fin(1, 16'h0);
  endtask

  task automatic t_link();
    u_link1.frame(1'b0, 2000);
    repeat (6) @(posedge clk);
    wb(1'b0, `DSB_OFS_STATUS_B, 32'h0);
    chk("stretch", 32'h0, q & 32'h2000_0000);
    cmd(1, 1'b0, `DSB_SRC_MSG);
    u_link1.frame(1'b1, 0);
    repeat (6) @(posedge clk);
    fin(1, 16'h0);
    wb(1'b0, `DSB_OFS_STATUS_B, 32'h0);
    chk("nack", 32'h2000_0000, q & 32'h6000_0000);
    cmd(1, 1'b0, `DSB_SRC_MANUAL);
    fin(1, 16'h0);
  endtask

  task automatic t_poll();
    int n;
    wb(1'b1, `DSB_OFS_CTRL, 32'h1);
    poll(1'b0);
    chk("index step", 32'h1, {29'h0, pollIndex[2:0]});
    poll(1'b1);
    chk("index held", 32'h1, {29'h0, pollIndex[2:0]});
    wb(1'b0, `DSB_OFS_STATUS_A, 32'h0);
    chk("poll error", 32'h2100_0000, q & 32'h2700_0000);
    n = 0;
    repeat (60) begin
      @(posedge clk);
      if (pollReq[0] !== 1'b0) n++;
    end
    chk("poll gated", 32'h0, n);
    cmd(0, 1'b0, `DSB_SRC_MANUAL);
    wb(1'b0, `DSB_OFS_STATUS_A, 32'h0);
    chk("error cleared", 32'h0100_0000, q & 32'h2700_0000);
    fin(0, 16'h0);
    poll(1'b0);
    chk("index resumed", 32'h2, {29'h0, pollIndex[2:0]});
    wb(1'b1, `DSB_OFS_CTRL, 32'h0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    {cyc, stb, we, sel, adr, wdat} = '0;
    {issue, isRd, src, done, rdData, grant} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_read();
    t_write();
    t_link();
    t_poll();
    end_sim();
  end
endmodule  // tb_dimm_sideband_bus_status
